//--- ssaw_ctrl.sv
// Purpose: Address capture, burst counter and write strobe control of a burst SRAM
// Assumes: Master drives all pins synchronously to mclk_i; no bus, plain ports
// Notes:   Linear burst order only; read path and sleep are handled elsewhere
//
// Contract
// - Capture address only when a strobe is valid and all chip selects active.
// - An address capture loads the two low address bits into the burst counter.
// - Each byte select writes its lane only when byte-write enable is low.
// - Global write low writes every lane regardless of the byte controls.
// - All synchronous inputs are sampled on the rising clock edge.
// - Burst counter steps on each edge where advance is sampled low, no strobe is valid and the last strobe selected the device.
// - Both strobes together count as a processor-strobe access.
// - Processor strobe is ignored while chip select one is high.
// - Chip selects are sampled only on edges with a valid address strobe.
// - Advance during a burst makes the next address internally.
`timescale 1ns/1ps

module ssaw_ctrl
    import ssaw_pkg::*;
#(
    parameter int ADDR_W = SSAW_ADDR_W,
    parameter int LANES  = SSAW_LANES,
    parameter int LANE_W = SSAW_LANE_W
)
(
    input  wire logic                    mclk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic [ADDR_W-1:0]       addr_i,
    input  wire logic                    processor_addr_strobe_n_i,
    input  wire logic                    controller_addr_strobe_n_i,
    input  wire logic                    burst_advance_n_i,
    input  wire logic                    chip_sel_one_n_i,
    input  wire logic                    chip_sel_two_i,
    input  wire logic                    chip_sel_three_n_i,
    input  wire logic                    global_write_n_i,
    input  wire logic                    byte_write_en_n_i,
    input  wire logic [LANES-1:0]        byte_write_sel_n_i,
    input  wire logic [LANES*LANE_W-1:0] wr_data_i,
    output logic      [ADDR_W-1:0]       addr_o,
    output logic                         selected_o,
    output logic                         proc_access_o,
    output logic                         addr_load_o,
    output logic      [LANES-1:0]        wr_lane_o,
    output logic      [LANES*LANE_W-1:0] wr_data_o
);

    localparam int HI_W = ADDR_W - SSAW_CNT_W;

    // ==========================================================
    // State
    typedef struct packed
    {
        ssaw_mode_t              mode;
        logic                    selected;
        logic                    proc_access;
        logic                    load;
        logic [HI_W-1:0]         addr_hi;
        logic [SSAW_CNT_W-1:0]   cnt;
        logic [LANES*LANE_W-1:0] data;
    } ssaw_ctrl_st_t;

    ssaw_ctrl_st_t st;
    ssaw_ctrl_st_t next_st;

    logic proc_ok;
    logic ctrl_ok;
    logic strobe;
    logic chips_on;
    logic load_sel;
    logic adv_step;

    // ==========================================================
    // Strobe qualification
    assign proc_ok  = !processor_addr_strobe_n_i && !chip_sel_one_n_i;
    assign ctrl_ok  = !controller_addr_strobe_n_i;
    assign strobe   = proc_ok || ctrl_ok;
    assign chips_on = !chip_sel_one_n_i && chip_sel_two_i && !chip_sel_three_n_i;
    assign load_sel = strobe && chips_on;
    assign adv_step = !strobe && !burst_advance_n_i && (st.mode == SSAW_ACTIVE);

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        next_st      = st;
        next_st.load = load_sel;
        next_st.data = wr_data_i;
        if (strobe)
        begin
            // Chip selects only looked at on a strobe edge
            next_st.selected = chips_on;
            next_st.mode     = chips_on ? SSAW_ACTIVE : SSAW_DESEL;
            if (chips_on)
            begin
                next_st.addr_hi     = addr_i[ADDR_W-1:SSAW_CNT_W];
                next_st.cnt         = addr_i[SSAW_CNT_W-1:0];
                next_st.proc_access = proc_ok;
            end
        end
        else if (adv_step)
        begin
            // Internal next address, upper bits untouched
            next_st.cnt = ssaw_cnt_step(st.cnt);
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st.mode        <= SSAW_IDLE;
            st.selected    <= SSAW_FLAG_RST;
            st.proc_access <= SSAW_FLAG_RST;
            st.load        <= SSAW_FLAG_RST;
            st.addr_hi     <= '0;
            st.cnt         <= SSAW_CNT_RST;
            st.data        <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Byte-lane write strobes
    ssaw_lane_dec #(
        .LANES (LANES)
    ) u_lane_dec (
        .mclk_i             (mclk_i),
        .sys_rst_i          (sys_rst_i),
        .global_write_n_i   (global_write_n_i),
        .byte_write_en_n_i  (byte_write_en_n_i),
        .byte_write_sel_n_i (byte_write_sel_n_i),
        .wr_lane_o          (wr_lane_o)
    );

    // Outputs straight from state
    assign addr_o        = {st.addr_hi, st.cnt};
    assign selected_o    = st.selected;
    assign proc_access_o = st.proc_access;
    assign addr_load_o   = st.load;
    assign wr_data_o     = st.data;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_adv_req;
        adv_step;
    endsequence

    sequence s_adv_done;
        ##1 (addr_o[SSAW_CNT_W-1:0] == ssaw_cnt_step($past(addr_o[SSAW_CNT_W-1:0])));
    endsequence

    property p_load_addr;
        load_sel |=> addr_o[ADDR_W-1:SSAW_CNT_W] == $past(addr_i[ADDR_W-1:SSAW_CNT_W]);
    endproperty
    a_load_addr: assert property (p_load_addr)
        else $error("address not captured on load");

    property p_no_load;
        (!strobe && burst_advance_n_i) |=> $stable(addr_o) && !addr_load_o;
    endproperty
    a_no_load: assert property (p_no_load)
        else $error("address changed without strobe or advance");

    property p_cnt_load;
        load_sel |=> addr_o[SSAW_CNT_W-1:0] == $past(addr_i[SSAW_CNT_W-1:0]) && addr_load_o;
    endproperty
    a_cnt_load: assert property (p_cnt_load)
        else $error("burst counter not loaded from low address bits");

    property p_lane_sel;
        (global_write_n_i && !byte_write_en_n_i) |=> wr_lane_o == ~$past(byte_write_sel_n_i);
    endproperty
    a_lane_sel: assert property (p_lane_sel)
        else $error("byte lanes do not follow qualified selects");

    property p_lane_off;
        (global_write_n_i && byte_write_en_n_i) |=> wr_lane_o == '0;
    endproperty
    a_lane_off: assert property (p_lane_off)
        else $error("lane written without byte-write enable");

    property p_global;
        !global_write_n_i |=> &wr_lane_o;
    endproperty
    a_global: assert property (p_global)
        else $error("global write did not enable all lanes");

    property p_advance;
        s_adv_req |-> s_adv_done;
    endproperty
    a_advance: assert property (p_advance)
        else $error("burst counter did not step on advance");

    property p_wrap_hi;
        adv_step |=> $stable(addr_o[ADDR_W-1:SSAW_CNT_W]) && !addr_load_o;
    endproperty
    a_wrap_hi: assert property (p_wrap_hi)
        else $error("upper address changed during burst");

    property p_prio;
        (proc_ok && ctrl_ok && chips_on) |=> proc_access_o;
    endproperty
    a_prio: assert property (p_prio)
        else $error("dual strobe not taken as processor access");

    property p_ce1_block;
        (!processor_addr_strobe_n_i && chip_sel_one_n_i && !ctrl_ok && burst_advance_n_i)
            |=> $stable(addr_o) && $stable(selected_o);
    endproperty
    a_ce1_block: assert property (p_ce1_block)
        else $error("processor strobe acted with chip select one high");

    property p_desel;
        (strobe && !chips_on) |=> !selected_o ##1 ($past(strobe) || $stable(selected_o));
    endproperty
    a_desel: assert property (p_desel)
        else $error("selection not held between load edges");

endmodule : ssaw_ctrl

//--- ssaw_pkg.sv
// Purpose: Shared constants, types and helpers for the address and write control block
// Assumes: One rising-edge clock, all control pins synchronous to it
// Notes:   Burst counter width is fixed at two bits by the address group size
package ssaw_pkg;

    // ==========================================================
    // Widths and defaults
    localparam int            SSAW_ADDR_W   = 20;
    localparam int            SSAW_LANES    = 4;
    localparam int            SSAW_LANE_W   = 8;
    localparam int            SSAW_CNT_W    = 2;

    // ==========================================================
    // Reset values and counter step
    localparam logic [1:0]    SSAW_CNT_RST  = 2'h0;
    localparam logic [1:0]    SSAW_CNT_ONE  = 2'h1;
    localparam logic          SSAW_FLAG_RST = 1'h0;

    // ==========================================================
    // Selection state of the last valid address strobe
    typedef enum logic [2:0]
    {
        SSAW_IDLE   = 3'b001,
        SSAW_ACTIVE = 3'b010,
        SSAW_DESEL  = 3'b100
    } ssaw_mode_t;

    // ==========================================================
    // Next burst location, wrapping inside the group of four
    function automatic logic [1:0] ssaw_cnt_step(input logic [1:0] cnt);
        ssaw_cnt_step = cnt + SSAW_CNT_ONE;
    endfunction : ssaw_cnt_step

endpackage : ssaw_pkg

//--- ssaw_lane_dec.sv
// Purpose: Registered byte-lane write strobe decode
// Assumes: Write controls are synchronous to mclk_i
// Notes:   Global write overrides the per-lane selects
`timescale 1ns/1ps

module ssaw_lane_dec
    import ssaw_pkg::*;
#(
    parameter int LANES = SSAW_LANES
)
(
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             global_write_n_i,
    input  wire logic             byte_write_en_n_i,
    input  wire logic [LANES-1:0] byte_write_sel_n_i,
    output logic      [LANES-1:0] wr_lane_o
);

    // ==========================================================
    // State
    typedef struct packed
    {
        logic [LANES-1:0] lane;
    } ssaw_lane_st_t;

    ssaw_lane_st_t st;
    ssaw_lane_st_t next_st;

    // Lane decode: global write, then qualified byte selects
    always_comb
    begin
        next_st = st;
        if (!global_write_n_i)
        begin
            next_st.lane = '1;
        end
        else if (!byte_write_en_n_i)
        begin
            next_st.lane = ~byte_write_sel_n_i;
        end
        else
        begin
            next_st.lane = '0;
        end
    end

    // State register, sampled on rising edge
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wr_lane_o = st.lane;

endmodule : ssaw_lane_dec

//--- ssaw_master.sv
// Purpose: Bus master model driving the pins of the address and write control block
// Assumes: Pins change only on the falling clock edge
// Notes:   Control groups are packed; the bench splits them onto the ports
`timescale 1ns/1ps

module ssaw_master
    import ssaw_pkg::*;
(
    input  wire logic                   mclk_i,
    output logic      [SSAW_ADDR_W-1:0] addr_o,
    output logic      [5:0]             ctl_o,
    output logic      [5:0]             wr_o,
    output logic      [31:0]            data_o
);
    // ==========================================================
    // Idle pins: no strobe, no advance, no write
    initial
    begin
        ctl_o  = 6'h3a;
        wr_o   = 6'h3f;
        addr_o = 20'h0;
        data_o = 32'h0;
    end

    // ==========================================================
    // One bus cycle, launched away from the sampling edge
    task automatic put(input logic [5:0] c, input logic [5:0] w, input logic [19:0] a);
        @(negedge mclk_i);
        ctl_o  <= c;
        wr_o   <= w;
        addr_o <= a;
        data_o <= {a[11:0], a};
    endtask : put
endmodule : ssaw_master

//--- tb_ssaw_ctrl.sv
// Purpose: Self-checking bench of the address and write control block
// Assumes: Outputs settle within 1 ns after the sampling edge
// Notes:   Row table first, then reset and post-reset advance
`timescale 1ns/1ps

`define CHK(n, e, a) compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, a); end

module tb_ssaw_ctrl;
    import ssaw_pkg::*;
    typedef struct packed {
        logic [5:0]  ctl;
        logic [5:0]  wr;
        logic [19:0] a;
        logic [19:0] ea;
        logic [2:0]  f;
        logic [3:0]  ln;
    } ssaw_row_t;

    logic        mclk_i;
    logic        sys_rst_i;
    logic [19:0] addr, addr_o;
    logic [5:0]  ctl, wr;
    logic [31:0] data, wr_data_o;
    logic        selected_o, proc_access_o, addr_load_o;
    logic [3:0]  wr_lane_o;
    int          error_cnt = 0;
    int          compares  = 0;
    // Controls {ps, cs, adv, cs1_n, cs2, cs3_n}; writes {gw, bwe, sel}
    ssaw_row_t   rows [14] = '{
        '{6'h1a, 6'h1f, 20'h50006, 20'h50006, 3'h7, 4'hf},
        '{6'h32, 6'h2e, 20'h00000, 20'h50007, 3'h6, 4'h1},
        '{6'h32, 6'h30, 20'h0aaaa, 20'h50004, 3'h6, 4'h0},
        '{6'h3a, 6'h25, 20'h05555, 20'h50004, 3'h6, 4'ha},
        '{6'h0a, 6'h0e, 20'h12343, 20'h12343, 3'h7, 4'hf},
        '{6'h22, 6'h23, 20'habcd1, 20'habcd1, 3'h5, 4'hc},
        '{6'h35, 6'h3f, 20'h0f0f0, 20'habcd2, 3'h4, 4'h0},
        '{6'h1e, 6'h2f, 20'h33333, 20'habcd2, 3'h4, 4'h0},
        '{6'h2e, 6'h20, 20'h44444, 20'habcd2, 3'h0, 4'hf},
        '{6'h32, 6'h2d, 20'h55555, 20'habcd2, 3'h0, 4'h2},
        '{6'h2a, 6'h3f, 20'h00003, 20'h00003, 3'h5, 4'h0},
        '{6'h28, 6'h3f, 20'hfffff, 20'h00003, 3'h0, 4'h0},
        '{6'h2a, 6'h3f, 20'h00010, 20'h00010, 3'h5, 4'h0},
        '{6'h2b, 6'h3f, 20'hfffff, 20'h00010, 3'h0, 4'h0}};

    // ==========================================================
    // Clock and design instances
    initial
    begin
        mclk_i = 1'h0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    ssaw_master m (.mclk_i(mclk_i), .addr_o(addr), .ctl_o(ctl), .wr_o(wr), .data_o(data));

    ssaw_ctrl uut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
        .processor_addr_strobe_n_i(ctl[5]), .controller_addr_strobe_n_i(ctl[4]),
        .burst_advance_n_i(ctl[3]), .chip_sel_one_n_i(ctl[2]),
        .chip_sel_two_i(ctl[1]), .chip_sel_three_n_i(ctl[0]),
        .global_write_n_i(wr[5]), .byte_write_en_n_i(wr[4]),
        .byte_write_sel_n_i(wr[3:0]), .wr_data_i(data),
        .addr_o(addr_o), .selected_o(selected_o), .proc_access_o(proc_access_o),
        .addr_load_o(addr_load_o), .wr_lane_o(wr_lane_o), .wr_data_o(wr_data_o));

    // ==========================================================
    // Verdict and end of run
    task automatic finish_test();
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (500) @(posedge mclk_i);
        error_cnt++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        sys_rst_i = 1'h1;
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'h0;
        foreach (rows[i])
        begin
            m.put(rows[i].ctl, rows[i].wr, rows[i].a);
            @(posedge mclk_i);
            #1;
            `CHK("addr_o", rows[i].ea, addr_o)
            `CHK("flags", rows[i].f, {selected_o, proc_access_o, addr_load_o})
            `CHK("wr_lane_o", rows[i].ln, wr_lane_o)
            `CHK("wr_data_o", {rows[i].a[11:0], rows[i].a}, wr_data_o)
        end
        // Asynchronous reset in mid-run clears every output
        @(negedge mclk_i);
        sys_rst_i = 1'h1;
        #1;
        `CHK("rst_flags", 7'h0, {selected_o, proc_access_o, addr_load_o, wr_lane_o})
        `CHK("rst_addr", 20'h0, addr_o)
        // Idle pins before release so the block leaves reset in idle mode
        m.put(6'h3a, 6'h3f, 20'h00000);
        sys_rst_i = 1'h0;
        // Advance straight after reset has no burst to step
        m.put(6'h32, 6'h3f, 20'h7ffff);
        @(posedge mclk_i);
        #1;
        `CHK("adv_idle", 20'h0, addr_o)
        `CHK("adv_idle_sel", 1'h0, selected_o)
        finish_test();
    end
endmodule : tb_ssaw_ctrl
